// ### core/sarcc_pkg.sv
// constants, types and register map of the successive-approximation converter control
package sarcc_pkg;

  // ---------------------------------------------------------------------------
  // register map: word index, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SARCC_IDX_SELECT   = 3'h0;
  localparam logic [2:0] SARCC_IDX_CONTROL  = 3'h1;
  localparam logic [2:0] SARCC_IDX_RES_LOW  = 3'h2;
  localparam logic [2:0] SARCC_IDX_RES_HIGH = 3'h3;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int SARCC_SEL_REF_HI  = 7;
  localparam int SARCC_SEL_REF_LO  = 6;
  localparam int SARCC_SEL_LEFT    = 5;
  localparam int SARCC_SEL_IN_HI   = 3;
  localparam int SARCC_CTL_ON      = 7;
  localparam int SARCC_CTL_GO      = 6;
  localparam int SARCC_CTL_FREE    = 5;
  localparam int SARCC_CTL_FLAG    = 4;
  localparam int SARCC_CTL_IE      = 3;
  localparam int SARCC_CTL_DIV_HI  = 2;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SARCC_SEL_RST    = 8'h00;
  localparam logic [7:0] SARCC_CTL_RST    = 8'h00;
  localparam logic [9:0] SARCC_RESULT_RST = 10'h000;
  localparam logic [6:0] SARCC_PRE_RST    = 7'h00;

  // ---------------------------------------------------------------------------
  // converter clock cycle counts, result width and first trial bit
  // ---------------------------------------------------------------------------
  localparam logic [4:0] SARCC_NORMAL_CYCLES = 5'h0D;
  localparam logic [4:0] SARCC_FIRST_CYCLES  = 5'h19;
  localparam logic [4:0] SARCC_HOLD_NORMAL   = 5'h01;
  localparam logic [4:0] SARCC_HOLD_FIRST    = 5'h0D;
  localparam logic [4:0] SARCC_RES_BITS      = 5'h0A;
  localparam logic [9:0] SARCC_SAR_MSB       = 10'h200;

  // ---------------------------------------------------------------------------
  // channel and reference codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SARCC_CH_LAST_PIN = 4'h7;
  localparam logic [3:0] SARCC_CH_BANDGAP  = 4'hE;
  localparam logic [3:0] SARCC_CH_GROUND   = 4'hF;
  localparam logic [1:0] SARCC_REF_PIN     = 2'h0;
  localparam logic [1:0] SARCC_REF_SUPPLY  = 2'h1;
  localparam logic [1:0] SARCC_REF_RSVD    = 2'h2;
  localparam logic [1:0] SARCC_REF_INT     = 2'h3;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SARCC_IDLE    = 2'h0,
    SARCC_ARMED   = 2'h1,
    SARCC_CONVERT = 2'h3
  } sarcc_state_e;

  typedef struct packed {
    logic [1:0] reference_select;
    logic [3:0] input_select;
    logic       input_connect;
  } sarcc_route_s;

endpackage : sarcc_pkg

// ### core/sarcc_top.sv
// control, timing and result logic of the successive-approximation converter
// How it works
// - binary search gives code vin*1024/vref
// - reference field picks pin, supply, internal
// - channel and reference locked during conversion
// - justify bit reshapes result view immediately
// - input field picks pin, bandgap, ground
// - enable on; clearing it aborts conversion
// - write one to go starts; zero ignored
// - first conversion 25 cycles, later 13
// - go bit reads one while converting
// - free run converts continuously until cleared
// - done flag set at every completion
// - flag cleared by vector or one written
// - interrupt when flag, enable, global set
// - prescaler divides by two up to 128
// - low byte read locks until high read
// - right or left byte layout, zeros elsewhere
// - start on next converter clock rising edge
// - sample at 1.5 or 13.5 cycles
// - free run restarts at completion, single stops
`timescale 1ns/10ps
module sarcc_top
  import sarcc_pkg::*;
(
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_clk_en,
  input  wire logic [4:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output      logic [31:0]        o_avs_readdata,
  output      logic               o_avs_waitrequest,
  input  wire logic               i_global_irq_en,
  input  wire logic               i_irq_ack,
  input  wire logic               i_comparator,
  output      logic               o_irq,
  output      logic               o_converter_on,
  output      logic               o_sample_hold,
  output      logic [9:0]         o_dac_code,
  output      sarcc_route_s       o_route
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic         wait_q;
  logic [31:0]  rdata_q;
  logic [1:0]   ref_q;
  logic         left_q;
  logic [3:0]   in_q;
  logic         on_q;
  logic         free_q;
  logic         flag_q;
  logic         ie_q;
  logic [2:0]   div_q;
  logic         irq_q;
  logic [6:0]   pre_q;
  logic [6:0]   div_m1;
  logic         rise_w;
  logic         fall_w;
  sarcc_state_e state_q;
  logic [4:0]   cyc_q;
  logic         long_q;
  logic         first_q;
  logic [9:0]   sar_q;
  logic [9:0]   sar_next;
  logic [9:0]   trial_bit;
  logic [4:0]   bit_idx;
  logic [4:0]   len_w;
  logic [4:0]   hold_w;
  logic [4:0]   bs_w;
  logic         hold_q;
  logic [9:0]   result_q;
  logic         lock_q;
  sarcc_route_s route_q;
  logic         cmp_s1;
  logic         cmp_s2;
  logic         cmp_s3;
  logic         cmp_q;
  logic [2:0]   idx_w;
  logic         capture;
  logic         accept;
  logic         wr_sel;
  logic         wr_ctl;
  logic         rd_low;
  logic         rd_high;
  logic         go_write;
  logic         abort_w;
  logic         done_evt;
  logic [7:0]   sel_view;
  logic [7:0]   ctl_view;
  logic [7:0]   low_view;
  logic [7:0]   high_view;
  logic [7:0]   rd_mux;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  assign idx_w    = i_avs_address[4:2];
  assign capture  = (i_avs_read | i_avs_write) & wait_q & i_clk_en;
  assign accept   = (i_avs_read | i_avs_write) & ~wait_q & i_clk_en;
  assign wr_sel   = accept & i_avs_write & i_avs_byteenable[0] & (idx_w == SARCC_IDX_SELECT);
  assign wr_ctl   = accept & i_avs_write & i_avs_byteenable[0] & (idx_w == SARCC_IDX_CONTROL);
  assign rd_low   = capture & i_avs_read & (idx_w == SARCC_IDX_RES_LOW);
  assign rd_high  = capture & i_avs_read & (idx_w == SARCC_IDX_RES_HIGH);
  assign go_write = wr_ctl & i_avs_writedata[SARCC_CTL_GO] & i_avs_writedata[SARCC_CTL_ON];
  assign abort_w  = wr_ctl & ~i_avs_writedata[SARCC_CTL_ON];

  // ---------------------------------------------------------------------------
  // register views
  // ---------------------------------------------------------------------------
  assign sel_view = {ref_q, left_q, 1'b0, in_q};
  assign ctl_view = {on_q, (state_q != SARCC_IDLE), free_q, flag_q, ie_q, div_q};
  assign low_view  = left_q ? {result_q[1:0], 6'h00} : result_q[7:0];
  assign high_view = left_q ? result_q[9:2] : {6'h00, result_q[9:8]};

  always_comb begin
    unique case (idx_w)
      SARCC_IDX_SELECT:   rd_mux = sel_view;
      SARCC_IDX_CONTROL:  rd_mux = ctl_view;
      SARCC_IDX_RES_LOW:  rd_mux = low_view;
      SARCC_IDX_RES_HIGH: rd_mux = high_view;
      default:            rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // bus handshake: one wait cycle, data captured on the first edge
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      wait_q <= ~capture;
      if (capture) begin
        rdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // channel and reference select register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ref_q  <= SARCC_SEL_RST[SARCC_SEL_REF_HI:SARCC_SEL_REF_LO];
      left_q <= SARCC_SEL_RST[SARCC_SEL_LEFT];
      in_q   <= SARCC_SEL_RST[SARCC_SEL_IN_HI:0];
    end else if (i_clk_en && wr_sel) begin
      ref_q  <= i_avs_writedata[SARCC_SEL_REF_HI:SARCC_SEL_REF_LO];
      left_q <= i_avs_writedata[SARCC_SEL_LEFT];
      in_q   <= i_avs_writedata[SARCC_SEL_IN_HI:0];
    end
  end

  // ---------------------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      on_q   <= SARCC_CTL_RST[SARCC_CTL_ON];
      free_q <= SARCC_CTL_RST[SARCC_CTL_FREE];
      ie_q   <= SARCC_CTL_RST[SARCC_CTL_IE];
      div_q  <= SARCC_CTL_RST[SARCC_CTL_DIV_HI:0];
    end else if (i_clk_en && wr_ctl) begin
      on_q   <= i_avs_writedata[SARCC_CTL_ON];
      free_q <= i_avs_writedata[SARCC_CTL_FREE];
      ie_q   <= i_avs_writedata[SARCC_CTL_IE];
      div_q  <= i_avs_writedata[SARCC_CTL_DIV_HI:0];
    end
  end

  // ---------------------------------------------------------------------------
  // done flag and interrupt request
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flag_q <= SARCC_CTL_RST[SARCC_CTL_FLAG];
    end else if (i_clk_en) begin
      if (done_evt) begin
        flag_q <= 1'b1;
      end else if (i_irq_ack || (wr_ctl && i_avs_writedata[SARCC_CTL_FLAG])) begin
        flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      irq_q <= 1'b0;
    end else if (i_clk_en) begin
      irq_q <= flag_q & ie_q & i_global_irq_en;
    end
  end

  // ---------------------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0] full;
    full = 8'h01 << div_q;
    if (div_q <= 3'h1) begin
      div_m1 = 7'h01;
    end else begin
      div_m1 = 7'(full - 8'h01);
    end
  end

  assign rise_w = on_q & (pre_q >= div_m1) & i_clk_en;
  assign fall_w = on_q & (pre_q == (div_m1 >> 1)) & i_clk_en;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pre_q <= SARCC_PRE_RST;
    end else if (i_clk_en) begin
      if (!on_q || rise_w) begin
        pre_q <= SARCC_PRE_RST;
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // comparator synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_s3 <= 1'b0;
      cmp_q  <= 1'b0;
    end else if (i_clk_en) begin
      cmp_s1 <= i_comparator;
      cmp_s2 <= cmp_s1;
      cmp_s3 <= cmp_s2;
      if (cmp_s2 == cmp_s3) begin
        cmp_q <= cmp_s3;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------------------
  assign len_w    = long_q ? SARCC_FIRST_CYCLES : SARCC_NORMAL_CYCLES;
  assign hold_w   = long_q ? SARCC_HOLD_FIRST : SARCC_HOLD_NORMAL;
  assign bs_w     = len_w - SARCC_RES_BITS;
  assign bit_idx  = cyc_q - bs_w;
  assign trial_bit = SARCC_SAR_MSB >> bit_idx;
  assign sar_next = (cmp_q ? sar_q : (sar_q & ~trial_bit)) | (trial_bit >> 1);
  assign done_evt = (state_q == SARCC_CONVERT) & rise_w & ~abort_w
                    & (cyc_q == (len_w - 5'h01));

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      first_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctl && i_avs_writedata[SARCC_CTL_ON] && !on_q) begin
        first_q <= 1'b1;
      end else if (state_q == SARCC_ARMED && rise_w) begin
        first_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state_q <= SARCC_IDLE;
      cyc_q   <= 5'h00;
      long_q  <= 1'b0;
      sar_q   <= 10'h000;
      hold_q  <= 1'b0;
    end else if (i_clk_en) begin
      hold_q <= 1'b0;
      if (abort_w || (!on_q && !go_write)) begin
        state_q <= SARCC_IDLE;
        cyc_q   <= 5'h00;
      end else begin
        unique case (state_q)
          SARCC_IDLE: begin
            if (go_write) begin
              state_q <= SARCC_ARMED;
            end
          end
          SARCC_ARMED: begin
            if (rise_w) begin
              state_q <= SARCC_CONVERT;
              cyc_q   <= 5'h00;
              long_q  <= first_q;
            end
          end
          SARCC_CONVERT: begin
            if (fall_w && cyc_q == hold_w) begin
              hold_q <= 1'b1;
            end
            if (rise_w) begin
              if (cyc_q == bs_w - 5'h01) begin
                sar_q <= SARCC_SAR_MSB;
              end else if (cyc_q >= bs_w) begin
                sar_q <= sar_next;
              end
              if (done_evt) begin
                cyc_q  <= 5'h00;
                long_q <= 1'b0;
                if (!free_q) begin
                  state_q <= SARCC_IDLE;
                end
              end else begin
                cyc_q <= cyc_q + 5'h01;
              end
            end
          end
          default: begin
            state_q <= SARCC_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // result register and read lock
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      lock_q <= 1'b0;
    end else if (i_clk_en) begin
      if (rd_low) begin
        lock_q <= 1'b1;
      end else if (rd_high) begin
        lock_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      result_q <= SARCC_RESULT_RST;
    end else if (i_clk_en && done_evt && !lock_q) begin
      result_q <= sar_next;
    end
  end

  // ---------------------------------------------------------------------------
  // applied channel and reference
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      route_q <= '0;
    end else if (i_clk_en && (state_q != SARCC_CONVERT || done_evt)) begin
      route_q.reference_select <= ref_q;
      route_q.input_select     <= in_q;
      route_q.input_connect    <= (in_q <= SARCC_CH_LAST_PIN) || (in_q >= SARCC_CH_BANDGAP);
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_irq             = irq_q;
  assign o_converter_on    = on_q;
  assign o_sample_hold     = hold_q;
  assign o_dac_code        = sar_q;
  assign o_route           = route_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_armed_edge;
    (state_q == SARCC_ARMED) && rise_w && on_q && !abort_w;
  endsequence

  sequence s_done_free;
    done_evt && free_q;
  endsequence

  property p_go_busy;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ((state_q == SARCC_CONVERT) && capture && i_avs_read && (idx_w == SARCC_IDX_CONTROL))
        |=> o_avs_readdata[SARCC_CTL_GO];
  endproperty
  a_go_busy: assert property (p_go_busy)
    else $error("go bit low during conversion");

  property p_abort;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      abort_w |=> (state_q == SARCC_IDLE) && !on_q;
  endproperty
  a_abort: assert property (p_abort)
    else $error("disable did not abort");

  property p_start_edge;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_armed_edge |=> (state_q == SARCC_CONVERT) && (cyc_q == 5'h00);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("start not on converter clock edge");

  property p_length;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      done_evt |-> (cyc_q == (long_q ? 5'h18 : 5'h0C));
  endproperty
  a_length: assert property (p_length)
    else $error("conversion length wrong");

  property p_free_restart;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      s_done_free |=> (state_q == SARCC_CONVERT) && (cyc_q == 5'h00) && !long_q;
  endproperty
  a_free_restart: assert property (p_free_restart)
    else $error("free run did not restart");

  property p_flag_set;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      done_evt |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("done flag not set");

  property p_flag_keep;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (wr_ctl && !i_avs_writedata[SARCC_CTL_FLAG] && !i_irq_ack && !done_evt) |=> $stable(flag_q);
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("zero write changed flag");

  property p_irq;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      i_clk_en |=> (o_irq == $past(flag_q && ie_q && i_global_irq_en));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request wrong");

  property p_lock;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (lock_q && !rd_high) |=> $stable(result_q);
  endproperty
  a_lock: assert property (p_lock)
    else $error("result changed while locked");

  property p_route_lock;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      ((state_q == SARCC_CONVERT) && !done_evt && $past(state_q) == SARCC_CONVERT)
        |=> $stable(o_route) [*1];
  endproperty
  a_route_lock: assert property (p_route_lock)
    else $error("route changed during conversion");

  property p_hold_time;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_sample_hold |-> (cyc_q == (long_q ? 5'h0D : 5'h01));
  endproperty
  a_hold_time: assert property (p_hold_time)
    else $error("sample hold at wrong time");

  property p_rise_gap;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      rise_w |=> !rise_w;
  endproperty
  a_rise_gap: assert property (p_rise_gap)
    else $error("converter clock faster than half");

  property p_rsvd;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (capture && i_avs_read && (idx_w == SARCC_IDX_SELECT)) |=> !o_avs_readdata[4];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit not zero");

endmodule // sarcc_top

// ### verif/sar_converter_control_tb_top.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
module sar_converter_control_tb_top;
  import sarcc_pkg::*;
  localparam logic [79:0] PINS = {40'h0, 10'h2A7, 10'h0, 10'h155, 10'h0};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic         gie = 1'b0;
  logic         ack = 1'b0;
  logic [4:0]   adr = 5'h00;
  logic [7:0]   wd = 8'h00;
  logic [31:0]  rdata;
  logic         wait_rq, irq, on, sh, cmp;
  logic [9:0]   dac;
  sarcc_route_s route;
  int           errors = 0;
  int           checks_done = 0;
  always #5 clk = ~clk;
  sarcc_top sarcc_top_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({24'h0, wd}),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
    .i_global_irq_en(gie), .i_irq_ack(ack), .i_comparator(cmp), .o_irq(irq),
    .o_converter_on(on), .o_sample_hold(sh), .o_dac_code(dac), .o_route(route));
  sarcc_analog_model #(.PIN_CODES(PINS), .BG_CODE(10'h1F0)) sarcc_analog_model_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_sample_hold(sh), .i_dac_code(dac),
    .i_route(route), .o_comparator(cmp));
  // --------
  // bus and check helpers
  // --------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wait_rq !== 1'b0);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrt(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({2'b00, q}, {2'b00, exp});
  endtask
  task automatic wait_done;
    logic [7:0] q = 8'h00;
    int n = 0;
    while (q[4] !== 1'b1 && n < 400) begin
      bus(1'b0, 5'h04, 8'h00, q);
      n++;
    end
    if (q[4] !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, q[4], 1'b1);
    end
  endtask
  task automatic convert(input logic [7:0] sel);
    wrt(5'h00, sel);
    wrt(5'h04, 8'hD3);
    wait_done();
  endtask
  // --------
  // scenarios
  // --------
  task automatic t_regs;
    rdc(5'h04, 8'h00);
    rdc(5'h08, 8'h00);
    rdc(5'h0C, 8'h00);
    rdc(5'h10, 8'h00);
    wrt(5'h00, 8'hFF);
    rdc(5'h00, 8'hEF);
  endtask
  task automatic t_route;
    wrt(5'h00, 8'hC5);
    @(posedge clk);
    chk({3'b000, route}, {3'b000, 2'h3, 4'h5, 1'b1});
    wrt(5'h00, 8'h09);
    @(posedge clk);
    chk({3'b000, route}, {3'b000, 2'h0, 4'h9, 1'b0});
  endtask
  task automatic t_first;
    wrt(5'h00, 8'h03);
    wrt(5'h04, 8'hCB);
    rdc(5'h04, 8'hCB);
    wait_done();
    rdc(5'h08, 8'hA7);
    rdc(5'h0C, 8'h02);
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    chk({9'h000, irq}, 10'h001);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rdc(5'h04, 8'h8B);
    chk({9'h000, irq}, 10'h000);
    gie <= 1'b0;
  endtask
  task automatic t_left;
    wrt(5'h00, 8'h23);
    rdc(5'h08, 8'hC0);
    rdc(5'h0C, 8'hA9);
  endtask
  task automatic t_codes;
    convert(8'h0F);
    rdc(5'h08, 8'h00);
    rdc(5'h0C, 8'h00);
    convert(8'h0E);
    rdc(5'h08, 8'hF0);
    rdc(5'h0C, 8'h01);
  endtask
  task automatic t_hold_sel;
    wrt(5'h00, 8'h03);
    wrt(5'h04, 8'hD3);
    repeat (10) @(posedge clk);
    wrt(5'h00, 8'h0F);
    wait_done();
    rdc(5'h08, 8'hA7);
    rdc(5'h0C, 8'h02);
  endtask
  task automatic t_lock;
    rdc(5'h08, 8'hA7);
    convert(8'h01);
    rdc(5'h0C, 8'h02);
  endtask
  task automatic t_abort;
    wrt(5'h04, 8'hD3);
    repeat (5) @(posedge clk);
    wrt(5'h04, 8'h00);
    rdc(5'h04, 8'h00);
    chk({9'h000, on}, 10'h000);
  endtask
  task automatic t_free;
    wrt(5'h00, 8'h01);
    wrt(5'h04, 8'hF3);
    wait_done();
    rdc(5'h04, 8'hF3);
    rdc(5'h08, 8'h55);
    rdc(5'h0C, 8'h01);
    wrt(5'h04, 8'h93);
    wait_done();
    rdc(5'h04, 8'h93);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_route();
    t_first();
    t_left();
    t_codes();
    t_hold_sel();
    t_lock();
    t_abort();
    t_free();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule // sar_converter_control_tb_top

// ### verif/sarcc_analog_model.sv
// analog multiplexer, sample-and-hold and comparator model for the converter bench
`timescale 1ns/10ps
module sarcc_analog_model
  import sarcc_pkg::*;
#(
  parameter logic [79:0] PIN_CODES = 80'h0,
  parameter logic [9:0]  BG_CODE   = 10'h100
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_sample_hold,
  input  wire logic [9:0]   i_dac_code,
  input  wire sarcc_route_s i_route,
  output      logic         o_comparator
);
  // --------
  // channel pick and sample
  // --------
  logic [9:0] chan_code;
  logic [9:0] held_q;
  always_comb begin
    chan_code = ~held_q;
    if (i_route.input_select == SARCC_CH_GROUND) begin
      chan_code = 10'h000;
    end else if (i_route.input_select == SARCC_CH_BANDGAP) begin
      chan_code = BG_CODE;
    end else if (i_route.input_connect) begin
      chan_code = PIN_CODES[10*i_route.input_select[2:0] +: 10];
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      held_q <= 10'h000;
    end else if (i_sample_hold) begin
      held_q <= chan_code;
    end
  end
  assign o_comparator = (held_q >= i_dac_code);
endmodule // sarcc_analog_model
